/* File: design/sysctl_bank_regs.svh */
/*
  Constants for the c9/c10/c11 system-control register bank: register numbers,
  field positions, reset values. Assumes inclusion by the bank; the checker and the bench use literals.
*/
`ifndef SYSCTL_BANK_REGS_SVH
`define SYSCTL_BANK_REGS_SVH

// primary register numbers
`define PRIMARY_PERF 4'h9
`define PRIMARY_MEMCTL 4'hA
`define PRIMARY_PRELOAD 4'hB
// secondary register numbers
`define SECONDARY_PERF_CTL 4'hC
`define SECONDARY_PERF_CNT 4'hD
`define SECONDARY_PERF_USR 4'hE
`define SECONDARY_LOCKDOWN 4'h0
`define SECONDARY_REMAP 4'h2
`define SECONDARY_PL_STAT 4'h0
`define SECONDARY_PL_CTL 4'h1
// reset values
`define RST_ZERO 32'h00000000
`define RST_PRIMARY_REMAP 32'h00098AA4
`define RST_NORMAL_REMAP 32'h44E048E0
// placement control fields
`define LOCK_VICTIM_HI 29
`define LOCK_VICTIM_LO 28
`define LOCK_PRESERVE_BIT 0
// preload identification fields
`define PLID_SIZE_HI 20
`define PLID_SIZE_LO 16
`define PLID_PRESENT_BIT 0
`define PL_SIZE_NONE 5'h00
`define PL_SIZE_4 5'h04
`define PL_SIZE_8 5'h08
`define PL_SIZE_16 5'h10
// user accessibility: bit 0 only
`define PLUA_MASK 32'h00000001
// parameter register: bits 31:30 read as zero
`define PLPC_MASK 32'h3FFFFFFF
// monitor user enable: bit 0 only
`define PMUE_MASK 32'h00000001

`endif

/* File: design/sysctl_bank_pkg.sv */
/*
  Types for the system-control register bank.
  Assumes nothing beyond a SystemVerilog compiler.
*/
package sysctl_bank_pkg;

  typedef struct packed {
    logic valid;
    logic write;
    logic [3:0] primary_reg_number;
    logic [2:0] opc1;
    logic [3:0] secondary_reg_number;
    logic [2:0] opc2;
    logic [31:0] wdata;
    logic privileged;
    logic nonsecure;
  } xfer_req_s;

  typedef struct packed {
    logic valid;
    logic undef;
    logic [31:0] rdata;
  } xfer_rsp_s;

  typedef struct packed {
    logic lockdown;
    logic [1:0] slot;
  } walk_place_s;

  typedef enum logic [1:0] {
    FIFO_NONE,
    FIFO_4,
    FIFO_8,
    FIFO_16
  } fifo_cfg_e;

endpackage

/* File: design/sysctl_c9_c11_bank.sv */
/*
  System-control register bank for primary numbers c9, c10 and c11, reached
  by coprocessor read and write transfers from the core. Holds the monitor
  register map, TLB placement control with memory remap, and the preload
  identification and control registers.
  Assumes the core presents one transfer per cycle as a single-cycle valid,
  with its mode and security state, and that walk results come from the TLB.
*/
`timescale 1ns/100ps

`include "sysctl_bank_regs.svh"

module sysctl_c9_c11_bank #(
  parameter logic PRELOAD_PRESENT = 1'b1,
  parameter sysctl_bank_pkg::fifo_cfg_e PRELOAD_FIFO = sysctl_bank_pkg::FIFO_16
) (
  // clock and reset
  input wire logic sys_clk_i,
  input wire logic rst_n_i,
  input wire logic clk_en_i,
  // coprocessor transfer from the core
  input wire sysctl_bank_pkg::xfer_req_s req_i,
  output sysctl_bank_pkg::xfer_rsp_s rsp_o,
  // non-secure tlb permission from the access control register
  input wire logic nonsecure_tlb_permission_i,
  // preload engine state
  input wire logic preload_active_i,
  input wire logic [4:0] preload_free_entries_i,
  // translation walk completion
  input wire logic walk_done_i,
  output sysctl_bank_pkg::walk_place_s walk_place_o,
  output logic walk_place_valid_o,
  // register values used by the core
  output logic [31:0] primary_region_remap_o,
  output logic [31:0] normal_memory_remap_o,
  output logic [31:0] preload_parameters_o,
  output logic preload_user_access_o,
  output logic software_increment_o,
  output logic [31:0] software_increment_bits_o
);

  ////////////////////////////////////////////////////////////////////////////
  // storage

  logic [31:0] perf_monitor_control_reg;
  logic [31:0] count_enable_reg;
  logic [31:0] overflow_flag_status_reg;
  logic [31:0] event_counter_select_reg;
  logic [31:0] cycle_counter_reg;
  logic [31:0] event_type_select_reg;
  logic [31:0] selected_event_counter_reg;
  logic [31:0] monitor_user_enable_reg;
  logic [31:0] monitor_irq_enable_reg;
  logic [1:0] lock_victim_reg;
  logic lock_preserve_reg;
  logic [31:0] primary_region_remap_reg;
  logic [31:0] normal_memory_remap_reg;
  logic [31:0] preload_user_access_reg;
  logic [31:0] preload_parameters_reg;

  ////////////////////////////////////////////////////////////////////////////
  // decode

  logic go;
  logic wr;
  logic rd;
  logic [10:0] group_code;
  logic sel_pmc;
  logic sel_pmcnt;
  logic sel_pmusr;
  logic sel_lock;
  logic sel_remap;
  logic sel_plstat;
  logic sel_plctl;
  logic [4:0] fifo_size;
  logic [31:0] preload_id_val;
  logic [31:0] rdata_next;
  logic hit_next;
  logic deny_next;

  assign go = clk_en_i && req_i.valid;
  assign wr = go && req_i.write;
  assign rd = go && !req_i.write;
  assign group_code = {req_i.primary_reg_number, req_i.opc1, req_i.secondary_reg_number};
  assign sel_pmc = group_code == {`PRIMARY_PERF, 3'h0, `SECONDARY_PERF_CTL};
  assign sel_pmcnt = group_code == {`PRIMARY_PERF, 3'h0, `SECONDARY_PERF_CNT};
  assign sel_pmusr = group_code == {`PRIMARY_PERF, 3'h0, `SECONDARY_PERF_USR};
  assign sel_lock = group_code == {`PRIMARY_MEMCTL, 3'h0, `SECONDARY_LOCKDOWN}
                    && req_i.opc2 == 3'h0;
  assign sel_remap = group_code == {`PRIMARY_MEMCTL, 3'h0, `SECONDARY_REMAP};
  assign sel_plstat = group_code == {`PRIMARY_PRELOAD, 3'h0, `SECONDARY_PL_STAT};
  assign sel_plctl = group_code == {`PRIMARY_PRELOAD, 3'h0, `SECONDARY_PL_CTL};

  always_comb begin
    fifo_size = `PL_SIZE_NONE;
    if (PRELOAD_PRESENT) begin
      case (PRELOAD_FIFO)
        sysctl_bank_pkg::FIFO_4: fifo_size = `PL_SIZE_4;
        sysctl_bank_pkg::FIFO_8: fifo_size = `PL_SIZE_8;
        sysctl_bank_pkg::FIFO_16: fifo_size = `PL_SIZE_16;
        default: fifo_size = `PL_SIZE_NONE;
      endcase
    end
  end

  always_comb begin
    preload_id_val = `RST_ZERO;
    preload_id_val[`PLID_SIZE_HI:`PLID_SIZE_LO] = fifo_size;
    preload_id_val[`PLID_PRESENT_BIT] = PRELOAD_PRESENT;
  end

  // read mux and access check; deny answers as undefined
  always_comb begin
    rdata_next = `RST_ZERO;
    hit_next = 1'b1;
    deny_next = 1'b0;
    if (sel_pmc) begin
      case (req_i.opc2)
        3'h0: rdata_next = perf_monitor_control_reg;
        3'h1: rdata_next = count_enable_reg;
        3'h2: rdata_next = count_enable_reg;
        3'h3: rdata_next = overflow_flag_status_reg;
        3'h4: rdata_next = `RST_ZERO;
        3'h5: rdata_next = event_counter_select_reg;
        default: hit_next = 1'b0;
      endcase
    end else if (sel_pmcnt) begin
      case (req_i.opc2)
        3'h0: rdata_next = cycle_counter_reg;
        3'h1: rdata_next = event_type_select_reg;
        3'h2: rdata_next = selected_event_counter_reg;
        default: hit_next = 1'b0;
      endcase
    end else if (sel_pmusr) begin
      case (req_i.opc2)
        3'h0: rdata_next = monitor_user_enable_reg;
        3'h1: rdata_next = monitor_irq_enable_reg;
        3'h2: rdata_next = monitor_irq_enable_reg;
        default: hit_next = 1'b0;
      endcase
    end else if (sel_lock) begin
      rdata_next[`LOCK_VICTIM_HI:`LOCK_VICTIM_LO] = lock_victim_reg;
      rdata_next[`LOCK_PRESERVE_BIT] = lock_preserve_reg;
      if (!req_i.privileged) begin
        deny_next = 1'b1;
      end
      if (req_i.nonsecure && !nonsecure_tlb_permission_i) begin
        deny_next = 1'b1;
      end
    end else if (sel_remap) begin
      case (req_i.opc2)
        3'h0: rdata_next = primary_region_remap_reg;
        3'h1: rdata_next = normal_memory_remap_reg;
        default: hit_next = 1'b0;
      endcase
    end else if (sel_plstat) begin
      case (req_i.opc2)
        3'h0: rdata_next = preload_id_val;
        3'h2: rdata_next = {31'h0, PRELOAD_PRESENT && preload_active_i};
        3'h4: rdata_next = PRELOAD_PRESENT ? {27'h0, preload_free_entries_i} : `RST_ZERO;
        default: hit_next = 1'b0;
      endcase
    end else if (sel_plctl) begin
      case (req_i.opc2)
        3'h0: rdata_next = preload_user_access_reg;
        3'h1: rdata_next = preload_parameters_reg;
        default: hit_next = 1'b0;
      endcase
      // without the engine these registers do not exist
      if (!PRELOAD_PRESENT) begin
        hit_next = 1'b0;
      end
    end else begin
      hit_next = 1'b0;
    end
    if (!hit_next) begin
      rdata_next = `RST_ZERO;
    end
  end

  // a write is carried out only when it targets a writable register for this mode
  logic wr_ok;
  logic user_wr;
  assign wr_ok = wr && hit_next && !deny_next;
  // user-mode writes to user read-only registers are dropped
  assign user_wr = wr_ok && req_i.privileged;

  ////////////////////////////////////////////////////////////////////////////
  // monitor registers

  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      perf_monitor_control_reg <= `RST_ZERO;
      count_enable_reg <= `RST_ZERO;
      overflow_flag_status_reg <= `RST_ZERO;
      event_counter_select_reg <= `RST_ZERO;
    end else if (wr_ok && sel_pmc) begin
      case (req_i.opc2)
        3'h0: perf_monitor_control_reg <= req_i.wdata;
        3'h1: count_enable_reg <= count_enable_reg | req_i.wdata;
        3'h2: count_enable_reg <= count_enable_reg & ~req_i.wdata;
        3'h3: overflow_flag_status_reg <= overflow_flag_status_reg & ~req_i.wdata;
        3'h5: event_counter_select_reg <= req_i.wdata;
        default: ;
      endcase
    end
  end

  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cycle_counter_reg <= `RST_ZERO;
      event_type_select_reg <= `RST_ZERO;
      selected_event_counter_reg <= `RST_ZERO;
    end else if (wr_ok && sel_pmcnt) begin
      case (req_i.opc2)
        3'h0: cycle_counter_reg <= req_i.wdata;
        3'h1: event_type_select_reg <= req_i.wdata;
        3'h2: selected_event_counter_reg <= req_i.wdata;
        default: ;
      endcase
    end
  end

  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      monitor_user_enable_reg <= `RST_ZERO;
      monitor_irq_enable_reg <= `RST_ZERO;
    end else if (wr_ok && sel_pmusr) begin
      case (req_i.opc2)
        3'h0: if (req_i.privileged) monitor_user_enable_reg <= req_i.wdata & `PMUE_MASK;
        3'h1: monitor_irq_enable_reg <= monitor_irq_enable_reg | req_i.wdata;
        3'h2: monitor_irq_enable_reg <= monitor_irq_enable_reg & ~req_i.wdata;
        default: ;
      endcase
    end
  end

  // increment pulse; counting itself lives elsewhere
  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      software_increment_o <= 1'b0;
      software_increment_bits_o <= `RST_ZERO;
    end else if (clk_en_i) begin
      software_increment_o <= wr_ok && sel_pmc && req_i.opc2 == 3'h4;
      software_increment_bits_o <= (wr_ok && sel_pmc && req_i.opc2 == 3'h4) ? req_i.wdata
                                   : `RST_ZERO;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // placement control and remap

  // only victim and preserve are stored
  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      lock_victim_reg <= 2'h0;
      lock_preserve_reg <= 1'b0;
    end else if (wr_ok && sel_lock) begin
      lock_victim_reg <= req_i.wdata[`LOCK_VICTIM_HI:`LOCK_VICTIM_LO];
      lock_preserve_reg <= req_i.wdata[`LOCK_PRESERVE_BIT];
    end
  end

  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      primary_region_remap_reg <= `RST_PRIMARY_REMAP;
      normal_memory_remap_reg <= `RST_NORMAL_REMAP;
    end else if (wr_ok && sel_remap) begin
      if (req_i.opc2 == 3'h0) begin
        primary_region_remap_reg <= req_i.wdata;
      end else begin
        normal_memory_remap_reg <= req_i.wdata;
      end
    end
  end

  // each walk lands in exactly one region
  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      walk_place_o <= '0;
      walk_place_valid_o <= 1'b0;
    end else if (clk_en_i) begin
      walk_place_valid_o <= walk_done_i;
      // preserve set picks the lockdown slot
      walk_place_o.lockdown <= lock_preserve_reg;
      walk_place_o.slot <= lock_preserve_reg ? lock_victim_reg : 2'h0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // preload control

  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      preload_user_access_reg <= `RST_ZERO;
      preload_parameters_reg <= `RST_ZERO;
    end else if (user_wr && sel_plctl) begin
      if (req_i.opc2 == 3'h0) begin
        preload_user_access_reg <= req_i.wdata & `PLUA_MASK;
      end else begin
        preload_parameters_reg <= req_i.wdata & `PLPC_MASK;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // answer and exported values

  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rsp_o <= '0;
    end else if (clk_en_i) begin
      rsp_o.valid <= go;
      rsp_o.undef <= go && (!hit_next || deny_next);
      rsp_o.rdata <= (rd && hit_next && !deny_next) ? rdata_next : `RST_ZERO;
    end
  end

  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      primary_region_remap_o <= `RST_PRIMARY_REMAP;
      normal_memory_remap_o <= `RST_NORMAL_REMAP;
      preload_parameters_o <= `RST_ZERO;
      preload_user_access_o <= 1'b0;
    end else if (clk_en_i) begin
      primary_region_remap_o <= primary_region_remap_reg;
      normal_memory_remap_o <= normal_memory_remap_reg;
      preload_parameters_o <= preload_parameters_reg;
      preload_user_access_o <= preload_user_access_reg[0];
    end
  end

endmodule

/* File: dv/sysctl_bank_asserts.sv */
/*
  Checker for the c9-c11 register bank, bound to the bank's ports.
  Assumes one clock domain and the bank's one-cycle answer.
*/
`timescale 1ns/100ps
module sysctl_bank_checker #(
  parameter logic PRELOAD_PRESENT = 1'b1,
  parameter sysctl_bank_pkg::fifo_cfg_e PRELOAD_FIFO = sysctl_bank_pkg::FIFO_16
) (
  // inputs of the bank
  input wire logic sys_clk_i,
  input wire logic rst_n_i,
  input wire logic clk_en_i,
  input wire sysctl_bank_pkg::xfer_req_s req_i,
  input wire logic nonsecure_tlb_permission_i,
  input wire logic preload_active_i,
  input wire logic [4:0] preload_free_entries_i,
  input wire logic walk_done_i,
  // outputs of the bank
  input wire sysctl_bank_pkg::xfer_rsp_s rsp_o,
  input wire sysctl_bank_pkg::walk_place_s walk_place_o,
  input wire logic walk_place_valid_o,
  input wire logic [31:0] primary_region_remap_o,
  input wire logic [31:0] normal_memory_remap_o,
  input wire logic [31:0] preload_parameters_o,
  input wire logic preload_user_access_o,
  input wire logic software_increment_o,
  input wire logic [31:0] software_increment_bits_o
);
  logic take;
  logic lock;
  logic [13:0] enc;
  assign take = clk_en_i && req_i.valid;
  assign enc = {req_i.primary_reg_number, req_i.opc1, req_i.secondary_reg_number, req_i.opc2};
  assign lock = take && (enc == 14'h2800);

  default clocking @(posedge sys_clk_i); endclocking
  default disable iff (!rst_n_i);
  //////////////////////////////////////////////////////////////////////////////
  resp_pulse_a: assert property (clk_en_i |=> rsp_o.valid == $past(req_i.valid))
    else $error("answer pulse does not follow request");
  unmapped_undef_a: assert property (
    take && enc[13:3] == {4'h9, 3'h0, 4'hC} && req_i.opc2 > 3'h5
    |=> rsp_o.undef && rsp_o.rdata == 32'h00000000) else $error("unmapped code accepted");
  lock_user_refuse_a: assert property (lock && !req_i.privileged |=> rsp_o.undef)
    else $error("user access to placement control");
  lock_ns_refuse_a: assert property (
    lock && req_i.nonsecure && !nonsecure_tlb_permission_i |=> rsp_o.undef)
    else $error("non-secure access without permission");
  lock_grant_a: assert property (
    lock && req_i.privileged && (!req_i.nonsecure || nonsecure_tlb_permission_i)
    |=> !rsp_o.undef) else $error("placement control refused");
  walk_answer_a: assert property (clk_en_i |=> walk_place_valid_o == $past(walk_done_i))
    else $error("walk placement not one per walk");
  remap_reset_a: assert property (!$past(rst_n_i) |->
    primary_region_remap_o == 32'h00098AA4 && normal_memory_remap_o == 32'h44E048E0)
    else $error("remap reset value wrong");
  id_low_bits_a: assert property (take && !req_i.write && enc == 14'h2C00
    |=> !rsp_o.undef && rsp_o.rdata[15:0] == {15'h0000, PRELOAD_PRESENT})
    else $error("preload id low bits wrong");
  swinc_pulse_a: assert property (
    take && req_i.write && req_i.privileged && enc == 14'h2464
    |=> software_increment_o && software_increment_bits_o == $past(req_i.wdata))
    else $error("increment pulse missing");
  ua_user_keep_a: assert property (
    take && req_i.write && !req_i.privileged && enc == 14'h2C08 && !$past(req_i.valid)
    |=> $stable(preload_user_access_o)) else $error("user write changed access bit");
endmodule

bind sysctl_c9_c11_bank sysctl_bank_checker #(
  .PRELOAD_PRESENT(PRELOAD_PRESENT), .PRELOAD_FIFO(PRELOAD_FIFO)
) i_chk (
  .sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i), .clk_en_i(clk_en_i), .req_i(req_i),
  .nonsecure_tlb_permission_i(nonsecure_tlb_permission_i), .rsp_o(rsp_o),
  .preload_active_i(preload_active_i), .preload_free_entries_i(preload_free_entries_i),
  .walk_done_i(walk_done_i), .walk_place_o(walk_place_o),
  .walk_place_valid_o(walk_place_valid_o), .primary_region_remap_o(primary_region_remap_o),
  .normal_memory_remap_o(normal_memory_remap_o), .preload_parameters_o(preload_parameters_o),
  .preload_user_access_o(preload_user_access_o), .software_increment_o(software_increment_o),
  .software_increment_bits_o(software_increment_bits_o)
);

/* File: dv/core_model.sv */
/*
  Core-side model: issues coprocessor transfers and walk completions.
  Assumes the bench ends each burst of transfers with idle.
*/
`timescale 1ns/100ps
module core_model (
  // clock
  input wire logic sys_clk_i,
  // towards the bank
  output sysctl_bank_pkg::xfer_req_s req_o,
  output logic walk_done_o
);
  initial begin
    req_o = '0;
    walk_done_o = 1'b0;
  end

  // back to back: the next call replaces the request at the next edge
  task automatic xfer(input logic w, input logic [3:0] pn, input logic [3:0] sn,
      input logic [2:0] o2, input logic [31:0] wd, input logic priv, input logic ns);
    @(posedge sys_clk_i);
    req_o <= {1'b1, w, pn, 3'h0, sn, o2, wd, priv, ns};
  endtask

  // released fields are inverted so a stale request never looks fresh
  task automatic idle();
    sysctl_bank_pkg::xfer_req_s r;
    @(posedge sys_clk_i);
    r = ~req_o;
    r.valid = 1'b0;
    req_o <= r;
  endtask

  task automatic walk();
    @(posedge sys_clk_i);
    walk_done_o <= 1'b1;
    @(posedge sys_clk_i);
    walk_done_o <= 1'b0;
  endtask
endmodule

/* File: dv/sysctl_c9_c11_register_bank_tb.sv */
/*
  Self-checking bench for the c9-c11 register bank with the core model.
  Assumes the default preload configuration: present, 16-entry fifo.
*/
`timescale 1ns/100ps
module sysctl_c9_c11_register_bank_tb;
  localparam logic [31:0] Z = 32'h00000000;
  logic sys_clk_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic clk_en_i = 1'b1;
  logic nonsecure_tlb_permission_i = 1'b0;
  logic preload_active_i = 1'b0;
  logic [4:0] preload_free_entries_i = 5'h00;
  logic walk_done_i;
  logic walk_place_valid_o;
  logic [31:0] primary_region_remap_o;
  logic [31:0] normal_memory_remap_o;
  logic [31:0] preload_parameters_o;
  logic preload_user_access_o;
  logic software_increment_o;
  logic [31:0] software_increment_bits_o;
  logic [31:0] inc_seen = 32'h00000000;
  logic [15:0] st = 16'h5FB8;
  int bad_count = 0;
  int checks_done = 0;
  sysctl_bank_pkg::xfer_req_s req_i;
  sysctl_bank_pkg::xfer_rsp_s rsp_o;
  sysctl_bank_pkg::walk_place_s walk_place_o;
  sysctl_bank_pkg::walk_place_s wexp;
  sysctl_bank_pkg::xfer_rsp_s q[$];
  sysctl_bank_pkg::walk_place_s wq[$];

  always #12.5 sys_clk_i = ~sys_clk_i;

  sysctl_c9_c11_bank i_dut (
    .sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i), .clk_en_i(clk_en_i), .req_i(req_i),
    .rsp_o(rsp_o), .nonsecure_tlb_permission_i(nonsecure_tlb_permission_i),
    .preload_active_i(preload_active_i), .preload_free_entries_i(preload_free_entries_i),
    .walk_done_i(walk_done_i), .walk_place_o(walk_place_o),
    .walk_place_valid_o(walk_place_valid_o), .primary_region_remap_o(primary_region_remap_o),
    .normal_memory_remap_o(normal_memory_remap_o), .preload_parameters_o(preload_parameters_o),
    .preload_user_access_o(preload_user_access_o), .software_increment_o(software_increment_o),
    .software_increment_bits_o(software_increment_bits_o)
  );
  core_model i_core (.sys_clk_i(sys_clk_i), .req_o(req_i), .walk_done_o(walk_done_i));
  //////////////////////////////////////////////////////////////////////////////
  function automatic logic [15:0] lfsr(input logic [15:0] x);
    return {x[14:0], x[15] ^ x[13] ^ x[12] ^ x[10]};
  endfunction

  task automatic chk(input string what, input logic [33:0] seen, input logic [33:0] exp);
    checks_done++;
    if (seen !== exp) begin
      bad_count++;
      $display("unexpected %s: expected %h, seen %h", what, exp, seen);
    end
  endtask

  task automatic print_verdict();
    $display("checks %0d, mismatches %0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  // md bit 0 selects user mode, bit 1 non-secure state
  task automatic op(input int w, input int pn, input int sn, input int o2,
      input logic [31:0] wd, input int md, input int u, input logic [31:0] rd);
    i_core.xfer(w[0], pn[3:0], sn[3:0], o2[2:0], wd, !md[0], md[1]);
    q.push_back({1'b1, u[0], rd});
  endtask

  task automatic walk_to(input logic ld, input logic [1:0] slot);
    i_core.idle();
    i_core.walk();
    wq.push_back({ld, slot});
  endtask

  // fifo count kept within the 16 entries of this configuration
  task automatic rnd();
    i_core.idle();
    st = lfsr(st);
    preload_active_i <= st[0];
    preload_free_entries_i <= {1'b0, st[4:1]};
  endtask
  //////////////////////////////////////////////////////////////////////////////
  always @(posedge sys_clk_i) begin
    if (rsp_o.valid === 1'b1) begin
      chk("answer", rsp_o, q.size() > 0 ? q.pop_front() : 34'h000000000);
    end
    if (walk_place_valid_o === 1'b1) begin
      wexp = wq.size() > 0 ? wq.pop_front() : 3'h0;
      chk("lockdown", walk_place_o.lockdown, wexp.lockdown);
      if (wexp.lockdown === 1'b1) chk("slot", walk_place_o.slot, wexp.slot);
    end
    // increment pulse carries the written word
    if (software_increment_o === 1'b1) inc_seen <= software_increment_bits_o;
  end

  initial begin
    repeat (2000) @(posedge sys_clk_i);
    bad_count++;
    print_verdict();
  end

  initial begin
    repeat (3) @(posedge sys_clk_i);
    rst_n_i <= 1'b1;
    @(posedge sys_clk_i);
    chk("primary remap", primary_region_remap_o, 32'h00098AA4);
    chk("normal remap", normal_memory_remap_o, 32'h44E048E0);
    for (int i = 0; i < 6; i++) op(0, 9, i < 3 ? 12 : 14, i % 3 + (i < 3 ? 1 : 0), Z, 0, 0, Z);
    op(0, 9, 14, 0, Z, 0, 0, Z);
    op(0, 10, 2, 0, Z, 0, 0, 32'h00098AA4);
    op(0, 10, 2, 1, Z, 0, 0, 32'h44E048E0);
    op(0, 10, 0, 0, Z, 0, 0, Z);
    op(1, 9, 12, 1, 32'h00000005, 0, 0, Z);
    op(1, 9, 12, 2, 32'h00000001, 0, 0, Z);
    op(0, 9, 12, 1, Z, 0, 0, 32'h00000004);
    op(1, 9, 12, 4, 32'h000000A5, 0, 0, Z);
    op(0, 9, 12, 4, Z, 0, 0, Z);
    op(0, 9, 12, 6, Z, 0, 1, Z);
    op(0, 9, 12, 7, Z, 0, 1, Z);
    op(1, 9, 13, 1, 32'h0000001B, 0, 0, Z);
    op(0, 9, 13, 1, Z, 0, 0, 32'h0000001B);
    op(1, 9, 14, 0, 32'h00000001, 0, 0, Z);
    op(1, 9, 14, 0, Z, 1, 0, Z);
    op(0, 9, 14, 0, Z, 0, 0, 32'h00000001);
    op(1, 10, 2, 1, 32'h12345678, 0, 0, Z);
    op(0, 10, 2, 1, Z, 0, 0, 32'h12345678);
    op(1, 10, 0, 0, 32'hFFFFFFFF, 0, 0, Z);
    op(0, 10, 0, 0, Z, 0, 0, 32'h30000001);
    op(1, 10, 0, 0, Z, 1, 1, Z);
    op(1, 10, 0, 0, Z, 2, 1, Z);
    op(0, 10, 0, 0, Z, 2, 1, Z);
    op(0, 10, 0, 0, Z, 0, 0, 32'h30000001);
    i_core.idle();
    nonsecure_tlb_permission_i <= 1'b1;
    for (int s = 0; s < 4; s++) begin
      op(1, 10, 0, 0, {2'h0, 2'(s), 28'h0000001}, 2, 0, Z);
      walk_to(1'b1, 2'(s));
    end
    op(1, 10, 0, 0, 32'h30000000, 0, 0, Z);
    walk_to(1'b0, 2'h0);
    for (int m = 0; m < 4; m++) op(0, 11, 0, 0, Z, m, 0, 32'h00100001);
    op(1, 11, 0, 0, 32'hFFFFFFFF, 0, 0, Z);
    op(0, 11, 0, 0, Z, 0, 0, 32'h00100001);
    op(0, 11, 0, 1, Z, 0, 1, Z);
    repeat (4) begin
      rnd();
      op(0, 11, 0, 2, Z, 1, 0, {31'h00000000, st[0]});
      op(0, 11, 0, 4, Z, 3, 0, {28'h0000000, st[4:1]});
    end
    op(1, 11, 1, 0, 32'hFFFFFFFF, 0, 0, Z);
    op(1, 11, 1, 1, 32'hFFFFFFFF, 0, 0, Z);
    i_core.idle();
    op(1, 11, 1, 0, Z, 1, 0, Z);
    op(1, 11, 1, 1, Z, 1, 0, Z);
    op(0, 11, 1, 0, Z, 1, 0, 32'h00000001);
    op(0, 11, 1, 1, Z, 0, 0, 32'h3FFFFFFF);
    // a write offered while the clock enable is low must never be taken
    i_core.idle();
    @(posedge sys_clk_i) clk_en_i <= 1'b0;
    i_core.xfer(1'b1, 4'hA, 4'h2, 3'h0, 32'hFFFFFFFF, 1'b1, 1'b0);
    i_core.idle();
    @(posedge sys_clk_i) clk_en_i <= 1'b1;
    op(0, 10, 2, 0, Z, 0, 0, 32'h00098AA4);
    i_core.idle();
    repeat (4) @(posedge sys_clk_i);
    chk("increment", inc_seen, 32'h000000A5);
    chk("normal remap", normal_memory_remap_o, 32'h12345678);
    chk("user access", preload_user_access_o, 1'b1);
    chk("parameters", preload_parameters_o, 32'h3FFFFFFF);
    chk("pending", 34'(q.size() + wq.size()), 34'h000000000);
    print_verdict();
  end
endmodule
